// ---- pkg/ckg_params.svh ----
// register offsets, field positions, reset values and timing counts of the clock control
`ifndef CKG_PARAMS_SVH
`define CKG_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define CKG_OFS_CTRL   8'h00
`define CKG_OFS_SLOT   8'h04
`define CKG_OFS_VCO    8'h08
`define CKG_OFS_XTAL   8'h0C
`define CKG_OFS_SS     8'h10
`define CKG_OFS_OUTEN  8'h14
`define CKG_OFS_STAT   8'h18

// ************************************************************
// control, slot, crystal and spread register fields
// ************************************************************
`define CKG_CTRL_TMR_EN   0
`define CKG_CTRL_TMR_SEL  2:1
`define CKG_CTRL_RST_EN   3
`define CKG_CTRL_DFS_EN   4
`define CKG_CTRL_BUS_MODE 5
`define CKG_CTRL_BUS_OE   6
`define CKG_CTRL_RST_PIN  7
`define CKG_CTRL_PIN_FUN  9:8
`define CKG_SLOT_BUS_SEL  1:0
`define CKG_SLOT_SEL      3:2
`define CKG_XTAL_XIN      4:0
`define CKG_XTAL_XOUT     12:8
`define CKG_SS_EN1        0
`define CKG_SS_EN2        1
`define CKG_SS_CENTER     2
`define CKG_SS_AMT        5:4

// ************************************************************
// reset values
// ************************************************************
`define CKG_RST_BUS_OE  1'b1
`define CKG_RST_OUTEN   3'h7
`define CKG_RST_XTAL    5'h02
`define CKG_RST_DIV     24'h000000

// ************************************************************
// timing
// ************************************************************
`define CKG_CLK_HZ       20000000
`define CKG_TMR_BASE_MS  500
`define CKG_RST_PULSE_MS 250
`define CKG_TMR_BASE_CYC (`CKG_TMR_BASE_MS * (`CKG_CLK_HZ / 1000))
`define CKG_RST_CYC      (`CKG_RST_PULSE_MS * (`CKG_CLK_HZ / 1000))

`endif

// ---- pkg/ckg_pkg.sv ----
// types shared by the clock generator control logic
package ckg_pkg;

	typedef enum logic [1:0] {
		CKG_PIN_OE    = 2'b00,
		CKG_PIN_PD    = 2'b01,
		CKG_PIN_PSAVE = 2'b10,
		CKG_PIN_FSEL  = 2'b11
	} ckg_pin_fun_e;

	typedef enum logic [1:0] {
		CKG_TMR_IDLE  = 2'b00,
		CKG_TMR_RUN   = 2'b01,
		CKG_TMR_PULSE = 2'b10,
		CKG_TMR_DONE  = 2'b11
	} ckg_tmr_e;

	typedef logic [23:0] ckg_div_t;

endpackage

// ---- tb/ckg_ctrl_chk.sv ----
// concurrent checks on the clock control ports
`timescale 1ns/1ns
module ckg_ctrl_chk #(
	parameter int unsigned RST_PULSE_CYC = 8,
	parameter int unsigned DIV_STEP      = 1
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              enable_pin_one_out,
	input wire logic              enable_pin_one_oe,
	input wire logic [2:0]        out_run,
	input wire logic              se1_low_power,
	input wire logic              sleep_mode,
	input wire logic              xtal_cal_on,
	input wire logic [1:0]        active_slot,
	input wire ckg_pkg::ckg_div_t fb_div,
	input wire logic              timeout_flag
);
	import ckg_pkg::*;
	logic [31:0] hi_cnt;
	logic [31:0] next_hi_cnt;
	logic        clr;
	// ************************************************************
	// pulse length counter
	// ************************************************************
	always_comb next_hi_cnt = enable_pin_one_out ? hi_cnt + 32'h1 : 32'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hi_cnt <= 32'h0;
		else hi_cnt <= next_hi_cnt;
	end
	assign clr = psel && penable && pready && pwrite && paddr == 8'h00 && !pwdata[0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pready_wait: assert property (psel && penable && !$past(penable) |=> pready)
		else $error("ready not one cycle after access");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_sleep_stops: assert property (sleep_mode |-> out_run[2:1] == 2'b00 && se1_low_power)
		else $error("outputs run in power down");
	a_cal_runs: assert property (xtal_cal_on)
		else $error("calibration stopped");
	a_flag_holds: assert property (timeout_flag && !clr |=> timeout_flag)
		else $error("flag dropped on its own");
	a_flag_clears: assert property (clr |-> ##2 !timeout_flag)
		else $error("flag not cleared");
	a_pulse_owned: assert property (enable_pin_one_out |-> enable_pin_one_oe && active_slot == 2'b00)
		else $error("pulse without pin drive or slot zero");
	a_pulse_len: assert property ($fell(enable_pin_one_out) |-> hi_cnt == RST_PULSE_CYC)
		else $error("reset pulse length wrong");
	a_ratio_ramp: assert property ({1'b0, fb_div} <= {1'b0, $past(fb_div)} + DIV_STEP &&
		{1'b0, $past(fb_div)} <= {1'b0, fb_div} + DIV_STEP)
		else $error("ratio jumped");
endmodule
bind ckg_ctrl ckg_ctrl_chk #(.RST_PULSE_CYC(RST_PULSE_CYC), .DIV_STEP(DIV_STEP)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.enable_pin_one_out(enable_pin_one_out), .enable_pin_one_oe(enable_pin_one_oe),
	.out_run(out_run), .se1_low_power(se1_low_power), .sleep_mode(sleep_mode),
	.xtal_cal_on(xtal_cal_on), .active_slot(active_slot), .fb_div(fb_div),
	.timeout_flag(timeout_flag));

// ---- tb/ckg_enddev.sv ----
// end device model that drives the shared enable pin from its power state
`timescale 1ns/1ns
module ckg_enddev (
	input  wire logic pclk,
	input  wire logic awake,
	input  wire logic pin_oe,
	input  wire logic pin_out,
	output logic      pin_in
);
	logic lvl;
	logic next_lvl;
	// the device answers one clock late, so the block never sees an instant pin
	always_comb next_lvl = awake;
	always_ff @(posedge pclk) lvl <= next_lvl;
	// once the block drives the pin, the end device only listens
	assign pin_in = pin_oe ? pin_out : lvl;
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the clock generator control block
`timescale 1ns/1ns
module tb_top;
	import ckg_pkg::*;
	typedef struct packed {
		logic [7:0]  a;
		logic        w;
		logic [31:0] d;
		logic [31:0] e;
		logic        r;
	} ckg_row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, awake, over, q_e;
	logic pin_in, pin_out, pin_oe, se1_low_power, sleep_mode, xtal_cal_on, ss1_on, timeout_flag;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  out_run;
	logic [1:0]  active_slot, ss1_amount;
	logic [4:0]  xin_cap, xout_cap;
	logic [47:0] sum;
	ckg_div_t    fb_div, fb_div_spread;
	int          errors, comparisons, n;
	ckg_row_s rows [16] = '{
		'{8'h00, 1'b0, 32'h0, 32'h40, 1'b0},
		'{8'h0C, 1'b0, 32'h0, 32'h202, 1'b0},
		'{8'h14, 1'b0, 32'h0, 32'h7, 1'b0},
		'{8'h10, 1'b0, 32'h0, 32'h0, 1'b0},
		'{8'h0C, 1'b1, 32'hA06, 32'h0, 1'b0},
		'{8'h0C, 1'b0, 32'h0, 32'hA06, 1'b0},
		'{8'h10, 1'b1, 32'h35, 32'h0, 1'b0},
		'{8'h10, 1'b0, 32'h0, 32'h35, 1'b0},
		'{8'h04, 1'b1, 32'h8, 32'h0, 1'b0},
		'{8'h08, 1'b1, 32'h10, 32'h0, 1'b0},
		'{8'h04, 1'b1, 32'hC, 32'h0, 1'b0},
		'{8'h08, 1'b1, 32'h300, 32'h0, 1'b0},
		'{8'h04, 1'b1, 32'h8, 32'h0, 1'b0},
		'{8'h08, 1'b0, 32'h0, 32'h10, 1'b0},
		'{8'h1C, 1'b0, 32'h0, 32'h0, 1'b1},
		'{8'h20, 1'b1, 32'h5, 32'h0, 1'b1}};
	ckg_ctrl #(.TMR_BASE_CYC(20), .RST_PULSE_CYC(8)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enable_pin_one_in(pin_in), .enable_pin_one_out(pin_out), .enable_pin_one_oe(pin_oe),
		.out_run(out_run), .se1_low_power(se1_low_power), .sleep_mode(sleep_mode),
		.xtal_cal_on(xtal_cal_on), .active_slot(active_slot), .fb_div(fb_div),
		.fb_div_spread(fb_div_spread), .ss1_on(ss1_on), .ss1_amount(ss1_amount),
		.xin_cap(xin_cap), .xout_cap(xout_cap), .timeout_flag(timeout_flag));
	ckg_enddev u_dev (.pclk(pclk), .awake(awake), .pin_oe(pin_oe), .pin_out(pin_out),
		.pin_in(pin_in));
	always #25 pclk = ~pclk;
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			k++;
			@(posedge pclk);
		end
		chk(k < 20, 1);
		q   = prdata;
		q_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic tk(input int c);
		repeat (c) @(posedge pclk);
	endtask
	task automatic ss_scan;
		sum  = 48'h0;
		over = 1'b0;
		repeat (1024) begin
			@(posedge pclk);
			sum = sum + 48'(fb_div_spread);
			if (fb_div_spread > fb_div) over = 1'b1;
		end
	endtask
	task automatic results;
		if (errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#2000000;
		errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		results;
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		awake = 1'b1;
		tk(8);
		chk(xin_cap, 32'h2);
		chk(xtal_cal_on, 1);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			if (!rows[i].w) chk(q, rows[i].e);
			chk(q_e, rows[i].r);
		end
		chk(xout_cap, 32'hA);
		chk(xin_cap, 32'h6);
		chk({ss1_on, ss1_amount}, 32'h7);
		awake <= 1'b0;
		tk(4);
		chk(out_run, 32'h6);
		awake <= 1'b1;
		wr(8'h00, 32'h0);
		tk(4);
		chk(out_run, 32'h0);
		wr(8'h00, 32'h40);
		wr(8'h14, 32'h5);
		tk(3);
		chk(out_run, 32'h5);
		wr(8'h14, 32'h7);
		wr(8'h00, 32'h140);
		awake <= 1'b0;
		tk(4);
		chk({sleep_mode, se1_low_power, out_run[2:1]}, 32'hC);
		awake <= 1'b1;
		tk(4);
		chk({sleep_mode, out_run}, 32'h7);
		wr(8'h00, 32'h240);
		awake <= 1'b0;
		tk(4);
		chk({sleep_mode, se1_low_power, out_run[2:1]}, 32'h7);
		awake <= 1'b1;
		tk(4);
		chk(se1_low_power, 0);
		wr(8'h00, 32'h350);
		tk(4);
		chk(active_slot, 32'h1);
		awake <= 1'b0;
		tk(4);
		chk(active_slot, 32'h0);
		wr(8'h04, 32'hB);
		wr(8'h00, 32'h50);
		tk(4);
		chk(active_slot, 32'h0);
		wr(8'h00, 32'h70);
		tk(4);
		chk(active_slot, 32'h3);
		tk(800);
		chk(fb_div, 32'h300);
		wr(8'h10, 32'h32);
		tk(4);
		ss_scan;
		chk({over, sum < 48'h300 * 1024}, 32'h1);
		wr(8'h10, 32'h36);
		tk(4);
		ss_scan;
		chk(sum / 1024 >= 48'h2FD && sum / 1024 <= 48'h303, 1);
		wr(8'h00, 32'h40);
		for (int s = 0; s < 4; s++) begin
			wr(8'h00, 32'h41 | (s << 1));
			n = 0;
			while (timeout_flag !== 1'b1 && n < 400) begin
				@(posedge pclk);
				n++;
			end
			chk(n >= (20 << s) && n <= (20 << s) + 3, 1);
			wr(8'h00, 32'h40);
			tk(2);
			chk(timeout_flag, 0);
		end
		wr(8'h00, 32'h41);
		tk(10);
		wr(8'h00, 32'h40);
		tk(60);
		chk(timeout_flag, 0);
		wr(8'h04, 32'h3);
		wr(8'h00, 32'hF9);
		tk(4);
		chk({pin_oe, active_slot}, 32'h7);
		n = 0;
		while (pin_out !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk(active_slot, 32'h0);
		n = 0;
		while (pin_out === 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		chk(n, 32'd8);
		tk(2);
		apb(8'h00, 1'b0, 32'h0);
		chk(q, 32'hE9);
		chk(timeout_flag, 1);
		apb(8'h18, 1'b0, 32'h0);
		chk(q, 32'hE1);
		presetn <= 1'b0;
		tk(2);
		presetn <= 1'b1;
		apb(8'h00, 1'b0, 32'h0);
		chk(q, 32'h40);
		results;
	end
endmodule

// ---- verilog/ckg_ctrl.sv ----
// digital control of the clock generator: slots, pin function, timer, output gating, spread
`timescale 1ns/1ns
`include "ckg_params.svh"

module ckg_ctrl #(
	parameter int unsigned TMR_BASE_CYC  = `CKG_TMR_BASE_CYC,
	parameter int unsigned RST_PULSE_CYC = `CKG_RST_CYC,
	parameter int unsigned DIV_STEP      = 1,
	parameter int unsigned SS_PH_BITS    = 8
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic            enable_pin_one_in,
	output logic                 enable_pin_one_out,
	output logic                 enable_pin_one_oe,
	output logic      [2:0]      out_run,
	output logic                 se1_low_power,
	output logic                 sleep_mode,
	output logic                 xtal_cal_on,
	output logic      [1:0]      active_slot,
	output ckg_pkg::ckg_div_t    fb_div,
	output ckg_pkg::ckg_div_t    fb_div_spread,
	output logic                 ss1_on,
	output logic      [1:0]      ss1_amount,
	output logic      [4:0]      xin_cap,
	output logic      [4:0]      xout_cap,
	output logic                 timeout_flag
);
	import ckg_pkg::*;

	// ************************************************************
	// register state
	// ************************************************************
	logic              tmr_en, rst_en, dfs_en, bus_mode, bus_oe, rst_pin;
	logic [1:0]        tmr_sel, slot_sel, bus_fsel, ss_amt;
	ckg_pin_fun_e      pin_fun;
	ckg_div_t          slot_mem [4];
	logic [4:0]        xin, xout;
	logic              ss_en1, ss_en2, ss_center;
	logic [2:0]        out_en;
	logic              next_tmr_en, next_rst_en, next_dfs_en, next_bus_mode;
	logic              next_bus_oe, next_rst_pin;
	logic [1:0]        next_tmr_sel, next_slot_sel, next_bus_fsel, next_ss_amt;
	ckg_pin_fun_e      next_pin_fun;
	ckg_div_t          next_slot_mem [4];
	logic [4:0]        next_xin, next_xout;
	logic              next_ss_en1, next_ss_en2, next_ss_center;
	logic [2:0]        next_out_en;
	logic [31:0]       next_prdata;
	logic              next_pready, next_pslverr;
	logic              wr, rd_now;
	logic              expire, pulse_end;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `CKG_OFS_CTRL) || (a == `CKG_OFS_SLOT) || (a == `CKG_OFS_VCO)
			|| (a == `CKG_OFS_XTAL) || (a == `CKG_OFS_SS) || (a == `CKG_OFS_OUTEN)
			|| (a == `CKG_OFS_STAT);
	endfunction

	// one wait state: pready rises on the second access cycle
	assign rd_now = psel & penable & ~pready;
	assign wr     = psel & penable & pready & pwrite & mapped(paddr);

	always_comb begin
		next_tmr_en    = tmr_en;
		next_tmr_sel   = tmr_sel;
		next_rst_en    = rst_en;
		next_dfs_en    = dfs_en;
		next_bus_mode  = bus_mode;
		next_bus_oe    = bus_oe;
		next_rst_pin   = rst_pin;
		next_pin_fun   = pin_fun;
		next_slot_sel  = slot_sel;
		next_bus_fsel  = bus_fsel;
		next_slot_mem  = slot_mem;
		next_xin       = xin;
		next_xout      = xout;
		next_ss_en1    = ss_en1;
		next_ss_en2    = ss_en2;
		next_ss_center = ss_center;
		next_ss_amt    = ss_amt;
		next_out_en    = out_en;
		if (wr) begin
			if (paddr == `CKG_OFS_CTRL) begin
				next_tmr_en   = pwdata[`CKG_CTRL_TMR_EN];
				next_tmr_sel  = pwdata[`CKG_CTRL_TMR_SEL];
				next_rst_en   = pwdata[`CKG_CTRL_RST_EN];
				next_dfs_en   = pwdata[`CKG_CTRL_DFS_EN];
				next_bus_mode = pwdata[`CKG_CTRL_BUS_MODE];
				next_bus_oe   = pwdata[`CKG_CTRL_BUS_OE];
				next_rst_pin  = pwdata[`CKG_CTRL_RST_PIN];
				next_pin_fun  = ckg_pin_fun_e'(pwdata[`CKG_CTRL_PIN_FUN]);
			end else if (paddr == `CKG_OFS_SLOT) begin
				next_slot_sel = pwdata[`CKG_SLOT_SEL];
				next_bus_fsel = pwdata[`CKG_SLOT_BUS_SEL];
			end else if (paddr == `CKG_OFS_VCO) begin
				next_slot_mem[slot_sel] = pwdata[23:0];
			end else if (paddr == `CKG_OFS_XTAL) begin
				next_xin  = pwdata[`CKG_XTAL_XIN];
				next_xout = pwdata[`CKG_XTAL_XOUT];
			end else if (paddr == `CKG_OFS_SS) begin
				next_ss_en1    = pwdata[`CKG_SS_EN1];
				next_ss_en2    = pwdata[`CKG_SS_EN2];
				next_ss_center = pwdata[`CKG_SS_CENTER];
				next_ss_amt    = pwdata[`CKG_SS_AMT];
			end else if (paddr == `CKG_OFS_OUTEN) begin
				next_out_en = pwdata[2:0];
			end
		end
		// switching is dropped once the expiry sequence ends
		if (pulse_end && dfs_en) begin
			next_dfs_en = 1'b0;
		end
		next_pready  = rd_now;
		next_pslverr = rd_now & ~mapped(paddr);
		next_prdata  = prdata;
		if (rd_now && !pwrite) begin
			if (paddr == `CKG_OFS_CTRL) begin
				next_prdata = {22'h0, pin_fun, rst_pin, bus_oe, bus_mode, dfs_en,
					rst_en, tmr_sel, tmr_en};
			end else if (paddr == `CKG_OFS_SLOT) begin
				next_prdata = {28'h0, slot_sel, bus_fsel};
			end else if (paddr == `CKG_OFS_VCO) begin
				next_prdata = {8'h00, slot_mem[slot_sel]};
			end else if (paddr == `CKG_OFS_XTAL) begin
				next_prdata = {19'h0, xout, 3'h0, xin};
			end else if (paddr == `CKG_OFS_SS) begin
				next_prdata = {26'h0, ss_amt, 1'b0, ss_center, ss_en2, ss_en1};
			end else if (paddr == `CKG_OFS_OUTEN) begin
				next_prdata = {29'h0, out_en};
			end else if (paddr == `CKG_OFS_STAT) begin
				next_prdata = {22'h0, sleep_mode, se1_low_power, out_run,
					enable_pin_one_out, enable_pin_one_in, active_slot, timeout_flag};
			end else begin
				next_prdata = 32'h0;
			end
		end else if (rd_now) begin
			next_prdata = 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_en    <= 1'b0;
			tmr_sel   <= 2'h0;
			rst_en    <= 1'b0;
			dfs_en    <= 1'b0;
			bus_mode  <= 1'b0;
			bus_oe    <= `CKG_RST_BUS_OE;
			rst_pin   <= 1'b0;
			pin_fun   <= CKG_PIN_OE;
			slot_sel  <= 2'h0;
			bus_fsel  <= 2'h0;
			for (int i = 0; i < 4; i++) begin
				slot_mem[i] <= `CKG_RST_DIV;
			end
			xin       <= `CKG_RST_XTAL;
			xout      <= `CKG_RST_XTAL;
			ss_en1    <= 1'b0;
			ss_en2    <= 1'b0;
			ss_center <= 1'b0;
			ss_amt    <= 2'h0;
			out_en    <= `CKG_RST_OUTEN;
			prdata    <= 32'h0;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
		end else begin
			tmr_en    <= next_tmr_en;
			tmr_sel   <= next_tmr_sel;
			rst_en    <= next_rst_en;
			dfs_en    <= next_dfs_en;
			bus_mode  <= next_bus_mode;
			bus_oe    <= next_bus_oe;
			rst_pin   <= next_rst_pin;
			pin_fun   <= next_pin_fun;
			slot_sel  <= next_slot_sel;
			bus_fsel  <= next_bus_fsel;
			slot_mem  <= next_slot_mem;
			xin       <= next_xin;
			xout      <= next_xout;
			ss_en1    <= next_ss_en1;
			ss_en2    <= next_ss_en2;
			ss_center <= next_ss_center;
			ss_amt    <= next_ss_amt;
			out_en    <= next_out_en;
			prdata    <= next_prdata;
			pready    <= next_pready;
			pslverr   <= next_pslverr;
		end
	end

	// ************************************************************
	// timeout timer and reset pulse
	// ************************************************************
	ckg_tmr_e    tmr_st, next_tmr_st;
	logic [31:0] tmr_cnt, next_tmr_cnt, tmr_len;
	logic        next_flag;

	assign tmr_len   = TMR_BASE_CYC << tmr_sel;
	assign expire    = (tmr_st == CKG_TMR_RUN) && (tmr_cnt == tmr_len - 32'h1);
	assign pulse_end = (expire && !rst_en)
		|| ((tmr_st == CKG_TMR_PULSE) && (tmr_cnt == RST_PULSE_CYC - 32'h1));

	always_comb begin
		next_tmr_st  = tmr_st;
		next_tmr_cnt = tmr_cnt + 32'h1;
		case (tmr_st)
			CKG_TMR_IDLE: begin
				next_tmr_cnt = 32'h0;
				if (tmr_en) begin
					next_tmr_st = CKG_TMR_RUN;
				end
			end
			CKG_TMR_RUN: begin
				if (!tmr_en) begin
					next_tmr_st = CKG_TMR_IDLE;
				end else if (expire) begin
					next_tmr_cnt = 32'h0;
					next_tmr_st  = rst_en ? CKG_TMR_PULSE : CKG_TMR_DONE;
				end
			end
			CKG_TMR_PULSE: begin
				if (pulse_end) begin
					next_tmr_cnt = 32'h0;
					next_tmr_st  = CKG_TMR_DONE;
				end
			end
			default: begin
				// one-shot: a new run needs enable cleared and set again
				next_tmr_cnt = 32'h0;
				if (!tmr_en) begin
					next_tmr_st = CKG_TMR_IDLE;
				end
			end
		endcase
		// expiry wins over a clearing write in the same cycle
		next_flag = timeout_flag;
		if (wr && paddr == `CKG_OFS_CTRL && !pwdata[`CKG_CTRL_TMR_EN]) begin
			next_flag = 1'b0;
		end
		if (expire) begin
			next_flag = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_st       <= CKG_TMR_IDLE;
			tmr_cnt      <= 32'h0;
			timeout_flag <= 1'b0;
		end else begin
			tmr_st       <= next_tmr_st;
			tmr_cnt      <= next_tmr_cnt;
			timeout_flag <= next_flag;
		end
	end

	// ************************************************************
	// pin function, output gating, slot and ratio stepping
	// ************************************************************
	logic [1:0]        next_slot;
	logic              next_pin_out, next_pin_oe, pd_n, next_lp, next_sleep;
	logic [2:0]        next_run;
	ckg_div_t          next_div, tgt, next_sdiv;
	logic [SS_PH_BITS-1:0] ph, next_ph;
	logic              ph_dn, next_ph_dn;
	logic [17:0]       amp;
	logic [25:0]       tri_full;
	logic [17:0]       tri_v;

	always_comb begin
		// reset output function overrides the two-bit pin field
		next_pin_oe  = rst_pin;
		next_pin_out = rst_pin && (next_tmr_st == CKG_TMR_PULSE);
		pd_n         = rst_pin || (pin_fun != CKG_PIN_PD) || enable_pin_one_in;
		next_sleep   = !pd_n;
		next_run     = (pd_n && bus_oe) ? out_en : 3'h0;
		if (!rst_pin && pin_fun == CKG_PIN_OE && !enable_pin_one_in) begin
			next_run[0] = 1'b0;
		end
		// low pin in power save mode means the end device is asleep
		next_lp = !pd_n
			|| (!rst_pin && pin_fun == CKG_PIN_PSAVE && !enable_pin_one_in);
		if (next_lp) begin
			next_run[0] = 1'b1;
		end
		next_slot = 2'h0;
		if (dfs_en && next_tmr_st != CKG_TMR_PULSE && !(expire && dfs_en)) begin
			// the FSEL pin function picks slot zero or one from the pin even without bus mode; otherwise without bus mode slot zero stays
			if (!rst_pin && pin_fun == CKG_PIN_FSEL) begin
				next_slot = {1'b0, enable_pin_one_in};
			end else if (bus_mode) begin
				next_slot = bus_fsel;
			end
		end
		// bounded step that lands exactly on target
		tgt      = slot_mem[next_slot];
		next_div = fb_div;
		if (tgt > fb_div) begin
			next_div = (tgt - fb_div > DIV_STEP[23:0]) ? fb_div + DIV_STEP[23:0] : tgt;
		end else if (tgt < fb_div) begin
			next_div = (fb_div - tgt > DIV_STEP[23:0]) ? fb_div - DIV_STEP[23:0] : tgt;
		end
		// triangle modulation; amp approximates amount plus one in 0.4% units of the ratio
		next_ph_dn = ph_dn;
		next_ph    = ph_dn ? ph - 1'b1 : ph + 1'b1;
		if (!ph_dn && &ph) begin
			next_ph_dn = 1'b1;
			next_ph    = ph;
		end else if (ph_dn && ph == '0) begin
			next_ph_dn = 1'b0;
			next_ph    = ph;
		end
		amp      = 18'(fb_div >> 8) * 18'({1'b0, ss_amt} + 3'h1);
		tri_full = 26'(amp) * 26'(ph);
		tri_v    = tri_full[SS_PH_BITS +: 18];
		next_sdiv = fb_div;
		if (ss_en2) begin
			if (ss_center) begin
				next_sdiv = fb_div + 24'(amp >> 1) - 24'(tri_v);
			end else begin
				next_sdiv = fb_div - 24'(tri_v);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_pin_one_out <= 1'b0;
			enable_pin_one_oe  <= 1'b0;
			out_run            <= 3'h0;
			se1_low_power      <= 1'b0;
			sleep_mode         <= 1'b0;
			xtal_cal_on        <= 1'b1;
			active_slot        <= 2'h0;
			fb_div             <= `CKG_RST_DIV;
			fb_div_spread      <= `CKG_RST_DIV;
			ss1_on             <= 1'b0;
			ss1_amount         <= 2'h0;
			xin_cap            <= `CKG_RST_XTAL;
			xout_cap           <= `CKG_RST_XTAL;
			ph                 <= '0;
			ph_dn              <= 1'b0;
		end else begin
			enable_pin_one_out <= next_pin_out;
			enable_pin_one_oe  <= next_pin_oe;
			out_run            <= next_run;
			se1_low_power      <= next_lp;
			sleep_mode         <= next_sleep;
			xtal_cal_on        <= 1'b1;
			active_slot        <= next_slot;
			fb_div             <= next_div;
			fb_div_spread      <= next_sdiv;
			ss1_on             <= ss_en1;
			ss1_amount         <= ss_amt;
			xin_cap            <= xin;
			xout_cap           <= xout;
			ph                 <= next_ph;
			ph_dn              <= next_ph_dn;
		end
	end

endmodule
